// *** rtl/dcsl_top.sv ***
`timescale 1ns/10ps
// Functional notes
// - Indicator green normal, yellow warning, red error.
// - Internal sources raise the warning condition.
// - User alarm request also raises warning.
// - Composed alarm output follows combined warning.
// - Error drives red indicator and supply output.
// - Button, computer or supervisory command clear latches.
// - User clear request also clears latched indicators.
// - Front ack pulse follows cancel button press.
// - Four groups hold independent near/far state.
// - Near request sets near, far request sets far.
// - Per group near and far outputs.
// - Outside enable gates requests; else touch screen.
// - Constant low and high outputs.
module dcsl_top #(
	parameter int unsigned GROUPS  = dcsl_pkg::GROUP_COUNT,
	parameter int unsigned LATCHES = 8
) (
	// Clock and reset.
	input  wire logic                                   REF_CLK_I,
	input  wire logic                                   RST_N_I,
	// Warning and error sources.
	input  wire logic [dcsl_pkg::WARN_SOURCE_COUNT-1:0] INTERNAL_WARN_I,
	input  wire logic                                   USER_ALARM_REQUEST_I,
	input  wire logic                                   ERROR_CONDITION_I,
	// Latched indicator sources and clear requests.
	input  wire logic [LATCHES-1:0]                     INDICATOR_SET_I,
	input  wire logic                                   CLEAR_BUTTON_I,
	input  wire logic                                   COMPUTER_CLEAR_I,
	input  wire logic                                   SUPERVISORY_CLEAR_I,
	input  wire logic                                   SUPERVISORY_ENABLE_I,
	input  wire logic                                   INDICATOR_CLEAR_REQUEST_I,
	input  wire logic                                   CANCEL_BUTTON_I,
	// Near/far control.
	input  wire logic                                   OUTSIDE_SELECT_ENABLE_I,
	input  wire logic [GROUPS-1:0]                      GROUP_NEAR_REQUEST_I,
	input  wire logic [GROUPS-1:0]                      GROUP_FAR_REQUEST_I,
	input  wire logic [GROUPS-1:0]                      TOUCH_TOGGLE_I,
	// Status outputs.
	output logic      [1:0]                             STATUS_COLOUR_O,
	output logic                                        COMPOSED_ALARM_OUT_O,
	output logic                                        SUPPLY_ERROR_OUT_O,
	output logic      [LATCHES-1:0]                     INDICATOR_LATCH_O,
	output logic                                        FRONT_ACK_PULSE_O,
	output logic      [GROUPS-1:0]                      GROUP_IS_NEAR_O,
	output logic      [GROUPS-1:0]                      GROUP_IS_FAR_O,
	output logic                                        CONST_LOW_O,
	output logic                                        CONST_HIGH_O
);
	import dcsl_pkg::*;

	// ==========================================================
	// Internal signals.

	// Combined warning condition from every warning source.
	logic               warn_d;
	// Any source that clears the latched indicators in this cycle.
	logic               clear_any;
	// Cancel button level of the previous cycle, for edge detection.
	logic               cancel_q;
	// Authority state, one bit per group, high for near.
	logic [GROUPS-1:0]  near_q;
	logic [GROUPS-1:0]  near_d;
	// Indicator colour for the next cycle.
	dcsl_colour_t       colour_d;
	// Latched indicator image for the next cycle.
	logic [LATCHES-1:0] latch_d;

	// ==========================================================
	// Helper functions.

	// Next authority state of one group from the outside requests.
	// Both requests together, or none, leave the state alone, so a
	// fault that raises both lines cannot flip authority.
	function automatic logic outside_next(
		input logic cur,
		input logic near_req,
		input logic far_req
	);
		logic nxt;
		nxt = cur;
		if (near_req && !far_req) begin
			nxt = 1'b1;
		end else if (far_req && !near_req) begin
			nxt = 1'b0;
		end else begin
			nxt = cur;
		end
		return nxt;
	endfunction

	// Next authority state of one group from the touch screen.
	function automatic logic touch_next(
		input logic cur,
		input logic toggle
	);
		logic nxt;
		nxt = cur;
		if (toggle) begin
			nxt = ~cur;
		end
		return nxt;
	endfunction

	// Next latched image. A set in the clearing cycle wins, so an
	// event that arrives together with a clear is never lost.
	function automatic logic [LATCHES-1:0] latch_next(
		input logic [LATCHES-1:0] cur,
		input logic [LATCHES-1:0] set_ev,
		input logic               clr
	);
		logic [LATCHES-1:0] nxt;
		nxt = cur | set_ev;
		if (clr) begin
			nxt = set_ev;
		end else begin
			nxt = cur | set_ev;
		end
		return nxt;
	endfunction

	// ==========================================================
	// Warning and error composition.

	// Internal sources and the user alarm request form one warning.
	assign warn_d = (|INTERNAL_WARN_I) | USER_ALARM_REQUEST_I;

	// Error outranks warning, and warning outranks normal operation.
	always_comb begin
		if (ERROR_CONDITION_I) begin
			colour_d = DCSL_RED;
		end else if (warn_d) begin
			colour_d = DCSL_YELLOW;
		end else begin
			colour_d = DCSL_GREEN;
		end
	end

	// Status indicator colour.
	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			STATUS_COLOUR_O <= DCSL_GREEN;
		end else begin
			STATUS_COLOUR_O <= colour_d;
		end
	end

	// Composed alarm output for further logic.
	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			COMPOSED_ALARM_OUT_O <= 1'b0;
		end else begin
			COMPOSED_ALARM_OUT_O <= warn_d;
		end
	end

	// Error output of the power supply section.
	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			SUPPLY_ERROR_OUT_O <= 1'b0;
		end else begin
			SUPPLY_ERROR_OUT_O <= ERROR_CONDITION_I;
		end
	end

	// ==========================================================
	// Latched indicators.

	// The supervisory clear only counts while that link is configured.
	assign clear_any = CLEAR_BUTTON_I | COMPUTER_CLEAR_I
			| (SUPERVISORY_CLEAR_I & SUPERVISORY_ENABLE_I)
			| INDICATOR_CLEAR_REQUEST_I;

	always_comb begin
		latch_d = latch_next(INDICATOR_LATCH_O, INDICATOR_SET_I, clear_any);
	end

	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			INDICATOR_LATCH_O <= {LATCHES{LATCH_RESET_VALUE}};
		end else begin
			INDICATOR_LATCH_O <= latch_d;
		end
	end

	// ==========================================================
	// Front acknowledge.

	// The previous level resets to released, the idle level of the
	// button, so no false press follows reset.
	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cancel_q <= 1'b0;
		end else begin
			cancel_q <= CANCEL_BUTTON_I;
		end
	end

	// One pulse on each press edge, however long the button is held.
	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			FRONT_ACK_PULSE_O <= 1'b0;
		end else begin
			FRONT_ACK_PULSE_O <= CANCEL_BUTTON_I & ~cancel_q;
		end
	end

	// ==========================================================
	// Near/far authority per group.

	// The setting picks the only source that may move authority.
	always_comb begin
		near_d = near_q;
		for (int g = 0; g < GROUPS; g++) begin
			if (OUTSIDE_SELECT_ENABLE_I) begin
				near_d[g] = outside_next(near_q[g], GROUP_NEAR_REQUEST_I[g], GROUP_FAR_REQUEST_I[g]);
			end else begin
				near_d[g] = touch_next(near_q[g], TOUCH_TOGGLE_I[g]);
			end
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			near_q <= {GROUPS{NEAR_RESET_VALUE}};
		end else begin
			near_q <= near_d;
		end
	end

	// Near outputs.
	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			GROUP_IS_NEAR_O <= {GROUPS{NEAR_RESET_VALUE}};
		end else begin
			GROUP_IS_NEAR_O <= near_q;
		end
	end

	// Far outputs, always the complement of the near outputs.
	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			GROUP_IS_FAR_O <= {GROUPS{~NEAR_RESET_VALUE}};
		end else begin
			GROUP_IS_FAR_O <= ~near_q;
		end
	end

	// ==========================================================
	// Constant outputs.

	// Constant low output.
	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			CONST_LOW_O <= 1'b0;
		end else begin
			CONST_LOW_O <= 1'b0;
		end
	end

	// Constant high output.
	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			CONST_HIGH_O <= 1'b1;
		end else begin
			CONST_HIGH_O <= 1'b1;
		end
	end

endmodule

// *** include/dcsl_pkg.sv ***
package dcsl_pkg;

	// ==========================================================
	// Sizes and reset values.
	localparam int unsigned GROUP_COUNT        = 4;
	localparam logic        NEAR_RESET_VALUE   = 1'b1;
	localparam logic        LATCH_RESET_VALUE  = 1'b0;
	localparam int unsigned WARN_SOURCE_COUNT  = 6;

	// ==========================================================
	// Internal warning source positions.
	localparam int unsigned WARN_NO_TIME_SYNC  = 0;
	localparam int unsigned WARN_BOOT_OPERABLE = 1;
	localparam int unsigned WARN_SETTING_ERROR = 2;
	localparam int unsigned WARN_NO_FREQ_SRC   = 3;
	localparam int unsigned WARN_MODE_NOT_NORM = 4;
	localparam int unsigned WARN_SIMULATION    = 5;

	// ==========================================================
	// Status indicator colours.
	typedef enum logic [1:0] {
		DCSL_GREEN,
		DCSL_YELLOW,
		DCSL_RED
	} dcsl_colour_t;

endpackage

// *** sim/dcsl_props.sv ***
`timescale 1ns/10ps
module dcsl_props import dcsl_pkg::*; #(parameter int unsigned GROUPS = 4, LATCHES = 8) (
	input wire logic REF_CLK_I, RST_N_I, USER_ALARM_REQUEST_I, ERROR_CONDITION_I, CANCEL_BUTTON_I,
	input wire logic CLEAR_BUTTON_I, COMPUTER_CLEAR_I, SUPERVISORY_CLEAR_I, SUPERVISORY_ENABLE_I,
	input wire logic INDICATOR_CLEAR_REQUEST_I, OUTSIDE_SELECT_ENABLE_I, FRONT_ACK_PULSE_O,
	input wire logic COMPOSED_ALARM_OUT_O, SUPPLY_ERROR_OUT_O,
	input wire logic [1:0] STATUS_COLOUR_O,
	input wire logic [WARN_SOURCE_COUNT-1:0] INTERNAL_WARN_I,
	input wire logic [LATCHES-1:0] INDICATOR_SET_I, INDICATOR_LATCH_O,
	input wire logic [GROUPS-1:0] GROUP_NEAR_REQUEST_I, GROUP_FAR_REQUEST_I, TOUCH_TOGGLE_I,
	input wire logic [GROUPS-1:0] GROUP_IS_NEAR_O, GROUP_IS_FAR_O
);
	wire warn = |INTERNAL_WARN_I | USER_ALARM_REQUEST_I;
	wire clr = CLEAR_BUTTON_I | COMPUTER_CLEAR_I | SUPERVISORY_CLEAR_I & SUPERVISORY_ENABLE_I | INDICATOR_CLEAR_REQUEST_I;
	wire en = OUTSIDE_SELECT_ENABLE_I;
	default clocking @(posedge REF_CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	sequence s_press;
		!CANCEL_BUTTON_I ##1 CANCEL_BUTTON_I;
	endsequence
	sequence s_pulse;
		FRONT_ACK_PULSE_O ##1 !FRONT_ACK_PULSE_O;
	endsequence
	a_colour_code: assert property (1 |=> STATUS_COLOUR_O ==
		($past(ERROR_CONDITION_I) ? DCSL_RED : $past(warn) ? DCSL_YELLOW : DCSL_GREEN)) else $error("colour");
	a_alarm_error: assert property (1 |=> COMPOSED_ALARM_OUT_O == $past(warn) &&
		SUPPLY_ERROR_OUT_O == $past(ERROR_CONDITION_I)) else $error("alarm");
	a_latch_hold: assert property (1 |=> INDICATOR_LATCH_O ==
		($past(INDICATOR_SET_I) | ($past(clr) ? '0 : $past(INDICATOR_LATCH_O)))) else $error("latch");
	a_ack_pulse: assert property (s_press |=> s_pulse) else $error("ack");
	a_near_set: assert property (en && GROUP_NEAR_REQUEST_I[0] && !GROUP_FAR_REQUEST_I[0] |=>
		##1 GROUP_IS_NEAR_O[0] && !GROUP_IS_FAR_O[0]) else $error("near");
	a_both_hold: assert property (en && GROUP_NEAR_REQUEST_I[1] && GROUP_FAR_REQUEST_I[1] |=>
		##1 $stable(GROUP_IS_NEAR_O[1])) else $error("both");
	a_outside_off: assert property (!en && TOUCH_TOGGLE_I == '0 |=> ##1 $stable(GROUP_IS_FAR_O)) else $error("gate");
	a_group_pair: assert property (GROUP_IS_NEAR_O == ~GROUP_IS_FAR_O) else $error("pair");
endmodule

// *** sim/dcsl_panel.sv ***
`timescale 1ns/10ps
module dcsl_panel (
	input  wire logic       clk_i,
	input  wire logic [1:0] cmd_i,
	output logic            cancel_o = 0,
	output logic            clear_o = 0
);
	always @(posedge clk_i) cancel_o <= cmd_i[0];
	always @(posedge clk_i) clear_o <= cmd_i[1];
endmodule

// *** sim/dcsl_top_tb.sv ***
`timescale 1ns/10ps
bind dcsl_top dcsl_props #(.GROUPS(GROUPS), .LATCHES(LATCHES)) u_dcsl_props (.*);
module dcsl_top_tb;
	import dcsl_pkg::*;
	logic REF_CLK_I = 0, RST_N_I = 0, USER_ALARM_REQUEST_I = 0, ERROR_CONDITION_I = 0, CLEAR_BUTTON_I = 0;
	logic COMPUTER_CLEAR_I = 0, SUPERVISORY_CLEAR_I = 0, SUPERVISORY_ENABLE_I = 0, OUTSIDE_SELECT_ENABLE_I = 0;
	logic CANCEL_BUTTON_I, INDICATOR_CLEAR_REQUEST_I, COMPOSED_ALARM_OUT_O, SUPPLY_ERROR_OUT_O, FRONT_ACK_PULSE_O;
	logic CONST_LOW_O, CONST_HIGH_O;
	logic [5:0] INTERNAL_WARN_I = 0;
	logic [7:0] INDICATOR_SET_I = 0, INDICATOR_LATCH_O;
	logic [3:0] GROUP_NEAR_REQUEST_I = 0, GROUP_FAR_REQUEST_I = 0, TOUCH_TOGGLE_I = 0, GROUP_IS_NEAR_O, GROUP_IS_FAR_O;
	logic [1:0] STATUS_COLOUR_O, cmd = 0;
	int mismatches = 0, n_tests = 0;
	dcsl_top u_dcsl_top (.*);
	dcsl_panel u_dcsl_panel (.clk_i(REF_CLK_I), .cmd_i(cmd), .cancel_o(CANCEL_BUTTON_I), .clear_o(INDICATOR_CLEAR_REQUEST_I));
	always #20 REF_CLK_I = ~REF_CLK_I;
	task chk(logic [15:0] got, logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task st(int n = 1);
		repeat (n) @(negedge REF_CLK_I);
	endtask
	task summarize;
		$display("%0d checks %0d mismatches", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task t_status;
		for (int i = 0; i < 9; i++) begin
			{ERROR_CONDITION_I, USER_ALARM_REQUEST_I, INTERNAL_WARN_I} = 8'h1 << i;
			st();
			chk(STATUS_COLOUR_O, i == 8 ? DCSL_GREEN : i == 7 ? DCSL_RED : DCSL_YELLOW);
			chk({SUPPLY_ERROR_OUT_O, COMPOSED_ALARM_OUT_O}, i == 8 ? 2'h0 : i == 7 ? 2'h2 : 2'h1);
		end
		$display("status test done");
	endtask
	task t_latch;
		for (int k = 0; k < 4; k++) begin
			INDICATOR_SET_I = 8'hff;
			st();
			INDICATOR_SET_I = 0;
			{SUPERVISORY_ENABLE_I, SUPERVISORY_CLEAR_I, COMPUTER_CLEAR_I, CLEAR_BUTTON_I} = k == 3 ? 4'h4 : k == 2 ? 4'hc : 4'h1 << k;
			st();
			{SUPERVISORY_ENABLE_I, SUPERVISORY_CLEAR_I, COMPUTER_CLEAR_I, CLEAR_BUTTON_I} = 0;
			chk(INDICATOR_LATCH_O, k == 3 ? 8'hff : 8'h0);
		end
		INDICATOR_SET_I = 8'h08;
		CLEAR_BUTTON_I = 1'b1;
		st();
		{INDICATOR_SET_I, CLEAR_BUTTON_I} = 9'h000;
		chk(INDICATOR_LATCH_O, 8'h08);
		cmd = 2'h2;
		st();
		cmd = 2'h0;
		st();
		chk(INDICATOR_LATCH_O, 8'h00);
		$display("latch test done");
	endtask
	task t_group;
		OUTSIDE_SELECT_ENABLE_I = 1;
		GROUP_FAR_REQUEST_I = 4'hf;
		st();
		{GROUP_NEAR_REQUEST_I, GROUP_FAR_REQUEST_I} = 8'h32;
		st();
		{OUTSIDE_SELECT_ENABLE_I, GROUP_NEAR_REQUEST_I, GROUP_FAR_REQUEST_I, TOUCH_TOGGLE_I} = 13'h0f04;
		st();
		chk({GROUP_IS_NEAR_O, GROUP_IS_FAR_O}, 8'h1e);
		{OUTSIDE_SELECT_ENABLE_I, GROUP_NEAR_REQUEST_I, GROUP_FAR_REQUEST_I, TOUCH_TOGGLE_I} = 13'h1001;
		st();
		chk({GROUP_IS_NEAR_O, GROUP_IS_FAR_O}, 8'h5a);
		TOUCH_TOGGLE_I = 0;
		st(2);
		chk({GROUP_IS_NEAR_O, GROUP_IS_FAR_O}, 8'h5a);
		$display("group test done");
	endtask
	task t_ack;
		cmd = 2'h1;
		st(2);
		chk(FRONT_ACK_PULSE_O, 1);
		st();
		chk(FRONT_ACK_PULSE_O, 0);
		cmd = 2'h0;
		st(2);
		$display("ack test done");
	endtask
	task t_reset;
		OUTSIDE_SELECT_ENABLE_I = 1'b1;
		GROUP_FAR_REQUEST_I = 4'hf;
		INDICATOR_SET_I = 8'h81;
		st();
		{OUTSIDE_SELECT_ENABLE_I, GROUP_FAR_REQUEST_I, INDICATOR_SET_I} = 13'h0000;
		st();
		chk({GROUP_IS_NEAR_O, INDICATOR_LATCH_O}, 12'h081);
		RST_N_I = 1'b0;
		#1;
		chk({GROUP_IS_NEAR_O, GROUP_IS_FAR_O, INDICATOR_LATCH_O}, 16'hf000);
		st(2);
		RST_N_I = 1'b1;
		st();
		chk({GROUP_IS_NEAR_O, GROUP_IS_FAR_O, INDICATOR_LATCH_O}, 16'hf000);
		chk({STATUS_COLOUR_O, FRONT_ACK_PULSE_O, CONST_HIGH_O, CONST_LOW_O}, 5'h02);
		$display("reset test done");
	endtask
	initial begin
		st(3);
		RST_N_I = 1'b1;
		st();
		chk({GROUP_IS_NEAR_O, GROUP_IS_FAR_O, CONST_HIGH_O, CONST_LOW_O}, 10'h3c2);
		t_status();
		t_latch();
		t_group();
		t_ack();
		t_reset();
		summarize();
	end
endmodule
